// *** logic/dsc_pkg.sv ***
// Constants and types of the D/A sequencer counting and fetch block.
// Operation
// - Normal mode performs programmed conversions per request.
// - Normal mode count zero converts continuously.
// - Normal mode halts at count, clears active.
// - Frame mode performs programmed conversions per trigger.
// - Frame mode count zero: continuous after trigger.
// - Frame mode halts at count, clears active.
// - One update pulse refreshes all channels together.
// - Pre-load next event data after each update.
// - Each event consumes four values per DAC.
// - Read-only 28-bit performed conversions counter.
// - Normal start clears performed counter.
// - Frame trigger clears counter only when not active.
// - FIFO fill level reported in bytes.
// - Each data value takes two bytes.
// - Base address is host buffer PCI address.
// - Base captured on length write while idle.
// - Length field counts host buffer bytes.
// - Length write starts the DMA transfer.
// - Length write ignored unless engine idle.
// - Next fetch address readable, read-only.
// - Idle flag shows a new buffer can be accepted.
package dsc_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_NUM = 12'h2f4;
  localparam logic [11:0] OFS_CNT = 12'h2f8;
  localparam logic [11:0] OFS_LVL = 12'h2fc;
  localparam logic [11:0] OFS_BASE = 12'h308;
  localparam logic [11:0] OFS_LEN = 12'h30c;
  localparam logic [11:0] OFS_NEXT = 12'h310;
  localparam logic [11:0] OFS_STAT = 12'h318;
  localparam int CNT_W = 28;
  localparam int FIFO_DEPTH = 16384;
  localparam int PTR_W = 14;
  localparam int LVL_W = 15;
  localparam logic [14:0] LVL_MAX_PUSH = 15'h3ffe;
  localparam logic [27:0] SAMPLE_BYTES = 28'h2;
  localparam logic [31:0] ADDR_STEP = 32'h2;
  localparam int NEED_W = 5;
  localparam int ST_ACT = 0;
  localparam int ST_IDLE = 1;
  localparam int ST_FRM_ERR = 2;
  localparam int ST_DAT_ERR = 3;
  localparam logic [27:0] NUM_RST = 28'h0;
  localparam logic [31:0] BASE_RST = 32'h0;
  localparam logic [27:0] LEN_RST = 28'h0;

  typedef enum logic [2:0] {
    DMA_IDLE,
    DMA_CHECK,
    DMA_REQ,
    DMA_WAIT,
    DMA_LO,
    DMA_HI
  } dsc_dma_t;

  typedef struct packed {
    logic [27:0] num;
    logic [27:0] count;
    logic [31:0] base;
    logic [27:0] len;
    logic [31:0] next_addr;
    logic [27:0] remain;
    dsc_dma_t dma;
    logic [31:0] word;
    logic [13:0] wr_ptr;
    logic [13:0] rd_ptr;
    logic [14:0] level;
    logic [4:0] pre_cnt;
    logic active;
    logic frm_err;
    logic dat_err;
    logic [15:0] dac_data;
    logic [3:0] dac_slot;
    logic dac_wr;
    logic dac_update;
    logic [31:0] rdata;
  } dsc_state_t;
endpackage

// *** logic/dsc_seq.sv ***
// Conversion counter, sample FIFO and host buffer fetch engine.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module dsc_seq (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic seq_enable,
  input wire logic frame_mode,
  input wire logic sw_start,
  input wire logic frame_trig,
  input wire logic conv_pulse,
  input wire logic [1:0] dac_devices_m1,
  output logic conversion_active_flag,
  output logic fetch_engine_idle_flag,
  output logic frame_error,
  output logic data_error,
  output logic dac_update,
  output logic dac_wr,
  output logic [3:0] dac_slot,
  output logic [15:0] dac_data,
  output logic mem_req,
  output logic [31:0] mem_addr,
  input wire logic mem_gnt,
  input wire logic mem_rvalid,
  input wire logic [31:0] mem_rdata
);

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [13:0] ptr_inc(input logic [13:0] p);
    ptr_inc = p + 14'h1;
  endfunction

  function automatic logic [4:0] need_of(input logic [1:0] m1);
    logic [2:0] n;
    n = {1'b0, m1} + 3'h1;
    need_of = {n, 2'b00};
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  dsc_pkg::dsc_state_t s_reg;
  dsc_pkg::dsc_state_t s_next;
  logic [15:0] fifo_mem [dsc_pkg::FIFO_DEPTH];
  logic [4:0] need;
  logic preloaded;
  logic pop;
  logic push;
  logic [15:0] push_data;
  logic conv_ev;
  logic conv_ok;
  logic no_err;
  logic norm_start;
  logic frm_trig_ev;
  logic frm_start;
  logic frm_fail;
  logic len_wr;
  logic [27:0] rem_dec;

  assign need = need_of(dac_devices_m1);
  assign preloaded = s_reg.pre_cnt == need;
  assign pop = !preloaded && s_reg.level != 15'h0 && seq_enable;
  assign push = s_reg.dma == dsc_pkg::DMA_LO ||
                s_reg.dma == dsc_pkg::DMA_HI;
  assign push_data = (s_reg.dma == dsc_pkg::DMA_LO) ?
                     s_reg.word[15:0] : s_reg.word[31:16];
  assign conv_ev = s_reg.active && conv_pulse && seq_enable;
  assign conv_ok = conv_ev && preloaded;
  assign no_err = !s_reg.frm_err && !s_reg.dat_err;
  assign norm_start = sw_start && !frame_mode && seq_enable && no_err;
  assign frm_trig_ev = frame_trig && frame_mode && seq_enable && no_err;
  assign frm_fail = frm_trig_ev && s_reg.active && s_reg.num != 28'h0;
  assign frm_start = frm_trig_ev && !s_reg.active;
  assign len_wr = reg_wr && reg_addr == dsc_pkg::OFS_LEN;
  assign rem_dec = s_reg.remain - dsc_pkg::SAMPLE_BYTES;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    s_next = s_reg;
    s_next.dac_wr = 1'b0;
    s_next.dac_update = 1'b0;
    s_next.rdata = 32'h0;
    // Conversion event: update all channels at once.
    if (conv_ev) begin
      if (preloaded) begin
        s_next.dac_update = 1'b1;
        s_next.count = s_reg.count + 28'h1;
        s_next.pre_cnt = 5'h0;
        // Stop at the programmed count, zero runs on.
        if (s_reg.num != 28'h0 && s_reg.count + 28'h1 == s_reg.num) begin
          s_next.active = 1'b0;
        end
      end else begin
        s_next.dat_err = 1'b1;
        s_next.active = 1'b0;
      end
    end
    // Software start restarts a block in normal mode.
    if (norm_start) begin
      s_next.active = 1'b1;
      s_next.count = 28'h0;
    end
    // Frame trigger starts a frame; a busy counted frame is an error.
    if (frm_fail) begin
      s_next.frm_err = 1'b1;
      s_next.active = 1'b0;
    end else if (frm_start) begin
      s_next.active = 1'b1;
      s_next.count = 28'h0;
    end
    if (!seq_enable) begin
      s_next.active = 1'b0;
      s_next.frm_err = 1'b0;
      s_next.dat_err = 1'b0;
    end
    // Pre-load pulls one value per cycle until the event set is full.
    if (pop) begin
      s_next.dac_data = fifo_mem[s_reg.rd_ptr];
      s_next.dac_slot = s_reg.pre_cnt[3:0];
      s_next.dac_wr = 1'b1;
      s_next.rd_ptr = ptr_inc(s_reg.rd_ptr);
      s_next.pre_cnt = s_reg.pre_cnt + 5'h1;
    end
    if (push) begin
      s_next.wr_ptr = ptr_inc(s_reg.wr_ptr);
    end
    s_next.level = s_reg.level + {14'h0, push} - {14'h0, pop};
    // Fetch engine.
    unique case (s_reg.dma)
      dsc_pkg::DMA_IDLE: begin
      end
      dsc_pkg::DMA_CHECK: begin
        if (s_reg.remain < dsc_pkg::SAMPLE_BYTES) begin
          s_next.remain = 28'h0;
          s_next.dma = dsc_pkg::DMA_IDLE;
        end else if (s_reg.level <= dsc_pkg::LVL_MAX_PUSH) begin
          s_next.dma = dsc_pkg::DMA_REQ;
        end
      end
      dsc_pkg::DMA_REQ: begin
        if (mem_gnt) begin
          s_next.dma = dsc_pkg::DMA_WAIT;
        end
      end
      dsc_pkg::DMA_WAIT: begin
        if (mem_rvalid) begin
          s_next.word = mem_rdata;
          s_next.dma = dsc_pkg::DMA_LO;
        end
      end
      dsc_pkg::DMA_LO, dsc_pkg::DMA_HI: begin
        // Each value takes two bytes of buffer and FIFO.
        s_next.remain = rem_dec;
        s_next.next_addr = s_reg.next_addr + dsc_pkg::ADDR_STEP;
        if (rem_dec < dsc_pkg::SAMPLE_BYTES) begin
          s_next.remain = 28'h0;
          s_next.dma = dsc_pkg::DMA_IDLE;
        end else if (s_reg.dma == dsc_pkg::DMA_LO) begin
          s_next.dma = dsc_pkg::DMA_HI;
        end else begin
          s_next.dma = dsc_pkg::DMA_CHECK;
        end
      end
    endcase
    // Register writes.
    if (reg_wr) begin
      unique case (reg_addr)
        dsc_pkg::OFS_NUM: s_next.num = reg_wdata[27:0];
        dsc_pkg::OFS_BASE: s_next.base = reg_wdata;
        default: begin
        end
      endcase
    end
    // Length write only counts while the engine is idle.
    if (len_wr && s_reg.dma == dsc_pkg::DMA_IDLE) begin
      s_next.len = reg_wdata[27:0];
      s_next.remain = reg_wdata[27:0];
      s_next.next_addr = s_reg.base;
      s_next.dma = dsc_pkg::DMA_CHECK;
    end
    // Register reads answer in the next cycle.
    if (reg_rd) begin
      unique case (reg_addr)
        dsc_pkg::OFS_NUM: s_next.rdata = {4'h0, s_reg.num};
        dsc_pkg::OFS_CNT: s_next.rdata = {4'h0, s_reg.count};
        dsc_pkg::OFS_LVL: s_next.rdata = {16'h0, s_reg.level, 1'b0};
        dsc_pkg::OFS_BASE: s_next.rdata = s_reg.base;
        dsc_pkg::OFS_LEN: s_next.rdata = {4'h0, s_reg.len};
        dsc_pkg::OFS_NEXT: s_next.rdata = s_reg.next_addr;
        dsc_pkg::OFS_STAT: begin
          s_next.rdata[dsc_pkg::ST_ACT] = s_reg.active;
          s_next.rdata[dsc_pkg::ST_IDLE] = s_reg.dma == dsc_pkg::DMA_IDLE;
          s_next.rdata[dsc_pkg::ST_FRM_ERR] = s_reg.frm_err;
          s_next.rdata[dsc_pkg::ST_DAT_ERR] = s_reg.dat_err;
        end
        default: s_next.rdata = 32'h0;
      endcase
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '0;
      s_reg.num <= dsc_pkg::NUM_RST;
      s_reg.base <= dsc_pkg::BASE_RST;
      s_reg.len <= dsc_pkg::LEN_RST;
      s_reg.dma <= dsc_pkg::DMA_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      fifo_mem[s_reg.wr_ptr] <= push_data;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign reg_rdata = s_reg.rdata;
  assign conversion_active_flag = s_reg.active;
  assign fetch_engine_idle_flag = s_reg.dma == dsc_pkg::DMA_IDLE;
  assign frame_error = s_reg.frm_err;
  assign data_error = s_reg.dat_err;
  assign dac_update = s_reg.dac_update;
  assign dac_wr = s_reg.dac_wr;
  assign dac_slot = s_reg.dac_slot;
  assign dac_data = s_reg.dac_data;
  assign mem_req = s_reg.dma == dsc_pkg::DMA_REQ;
  assign mem_addr = s_reg.next_addr;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  a_len_busy_ignored: assert property (
    len_wr && s_reg.dma != dsc_pkg::DMA_IDLE |=>
      $stable(s_reg.len) && s_reg.remain <= $past(s_reg.remain))
    else $error("length write accepted while busy");

  a_base_capture: assert property (
    len_wr && fetch_engine_idle_flag |=>
      mem_addr == $past(s_reg.base) && !fetch_engine_idle_flag)
    else $error("base not captured on length write");

  a_counted_stop: assert property (
    conv_ok && s_reg.num != 28'h0 && s_reg.count + 28'h1 == s_reg.num &&
      !norm_start && !frm_trig_ev |=> !conversion_active_flag)
    else $error("conversion did not stop at count");

  a_continuous_run: assert property (
    (conv_ok && s_reg.num == 28'h0) ##1 seq_enable |->
      conversion_active_flag)
    else $error("continuous conversion stopped");

  a_norm_clear: assert property (
    norm_start |=> s_reg.count == 28'h0 && conversion_active_flag)
    else $error("count not cleared on start");

  a_frame_error: assert property (
    frm_fail && seq_enable |=> frame_error &&
      s_reg.count == $past(s_reg.count) + 28'($past(conv_ok)))
    else $error("frame error handling wrong");

  a_level_bytes: assert property (
    reg_rd && reg_addr == dsc_pkg::OFS_LVL |=>
      reg_rdata == {16'h0, $past(s_reg.level), 1'b0})
    else $error("level not reported in bytes");

  a_update_full: assert property (
    dac_update |-> $past(s_reg.pre_cnt) == $past(need))
    else $error("update without full event set");

  a_preload_next: assert property (
    dac_update && seq_enable && s_reg.level >= 15'h10 ##1
      (seq_enable && !conv_pulse) [*8] |->
      ##[0:8] (preloaded || !seq_enable))
    else $error("next event not pre-loaded");

  a_fetch_step: assert property (
    push |=> mem_addr == $past(mem_addr) + dsc_pkg::ADDR_STEP)
    else $error("fetch address did not advance");

  a_fetch_space: assert property (
    mem_req |-> s_reg.level <= dsc_pkg::LVL_MAX_PUSH + 15'h1)
    else $error("fetch without FIFO space");

  c_counted_block: cover property (
    conv_ok && s_reg.num != 28'h0 ##1 !conversion_active_flag);
  c_frame_fail: cover property (frm_fail);
  c_fetch_done: cover property (push ##1 fetch_engine_idle_flag);
  c_len_ignored: cover property (len_wr && !fetch_engine_idle_flag);

endmodule
`default_nettype wire

// *** bench/dsc_mem_model.sv ***
// Host memory model that answers the fetch engine's read requests.
`timescale 1ns/1ps
`default_nettype none
module dsc_mem_model (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic slow,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  output logic mem_gnt,
  output logic mem_rvalid,
  output logic [31:0] mem_rdata
);
  logic ph;
  logic [1:0] dly;
  logic [31:0] adr;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ph <= 1'b0;
      dly <= 2'h0;
      adr <= 32'h0;
      mem_gnt <= 1'b0;
      mem_rvalid <= 1'b0;
      mem_rdata <= 32'h0;
    end else begin
      mem_gnt <= 1'b0;
      mem_rvalid <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (!ph && mem_req) begin
        dly <= dly + 2'h1;
        if (!slow || dly == 2'h3) begin
          mem_gnt <= 1'b1;
          adr <= mem_addr;
          ph <= 1'b1;
          dly <= 2'h0;
        end
      end else if (ph) begin
        dly <= dly + 2'h1;
        if (!slow || dly == 2'h2) begin
          mem_rvalid <= 1'b1;
          mem_rdata <= {adr[15:0] + 16'h2, adr[15:0]};
          ph <= 1'b0;
          dly <= 2'h0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
// Self-checking bench of the sequencer count and fetch block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [11:0] reg_addr = 12'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic seq_enable = 1'b0;
  logic frame_mode = 1'b0;
  logic sw_start = 1'b0;
  logic frame_trig = 1'b0;
  logic conv_pulse = 1'b0;
  logic slow = 1'b1;
  logic [1:0] devs = 2'h0;
  logic [31:0] reg_rdata, mem_addr, mem_rdata;
  logic [15:0] dac_data;
  logic [3:0] dac_slot;
  logic act, idle, frm_err, dat_err, upd, dac_wr, mem_req, mem_gnt, mem_rv;
  int error_cnt = 0;
  int cmp_count = 0;
  int wrc = 0;
  always #25 ref_clk = ~ref_clk;
  dsc_seq dut_u (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .seq_enable(seq_enable), .frame_mode(frame_mode),
    .sw_start(sw_start), .frame_trig(frame_trig), .conv_pulse(conv_pulse),
    .dac_devices_m1(devs), .conversion_active_flag(act),
    .fetch_engine_idle_flag(idle), .frame_error(frm_err),
    .data_error(dat_err), .dac_update(upd), .dac_wr(dac_wr),
    .dac_slot(dac_slot), .dac_data(dac_data), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_gnt(mem_gnt), .mem_rvalid(mem_rv),
    .mem_rdata(mem_rdata));
  dsc_mem_model mem_u (.ref_clk(ref_clk), .resetn(resetn), .slow(slow),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_gnt(mem_gnt),
    .mem_rvalid(mem_rv), .mem_rdata(mem_rdata));
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // Pre-loaded values arrive in buffer order, slots cycling 0..4*(devs+1)-1.
  always @(posedge ref_clk) begin
    if (dac_wr === 1'b1) begin
      chk("dac_data", 32'(16'(32'h100 + 2 * wrc)), {16'h0, dac_data});
      chk("dac_slot", 32'(wrc % (4 * (devs + 1))),
          {28'h0, dac_slot});
      wrc++;
    end
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), e, reg_rdata);
  endtask
  task automatic strobe(input int s);
    @(posedge ref_clk);
    sw_start <= (s == 0);
    frame_trig <= (s == 1);
    conv_pulse <= (s == 2);
    @(posedge ref_clk);
    sw_start <= 1'b0;
    frame_trig <= 1'b0;
    conv_pulse <= 1'b0;
    #1;
  endtask
  task automatic conv(input logic [27:0] cnt, input logic a);
    strobe(2);
    chk("dac_update", 32'h1, {31'h0, upd});
    repeat (8) @(posedge ref_clk);
    rd(dsc_pkg::OFS_CNT, {4'h0, cnt});
    chk("active", {31'h0, a}, {31'h0, act});
  endtask
  task automatic wait_idle();
    repeat (3) @(posedge ref_clk);
    for (int i = 0; i < 400 && idle !== 1'b1; i++) @(posedge ref_clk);
    #1 chk("idle", 32'h1, {31'h0, idle});
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    logic [11:0] ofs [7] = '{dsc_pkg::OFS_NUM, dsc_pkg::OFS_CNT,
      dsc_pkg::OFS_LVL, dsc_pkg::OFS_BASE, dsc_pkg::OFS_LEN,
      dsc_pkg::OFS_NEXT, 12'h7fc};
    chk("idle", 32'h1, {31'h0, idle});
    chk("active", 32'h0, {31'h0, act});
    foreach (ofs[i]) rd(ofs[i], 32'h0);
  endtask
  task automatic t_fetch();
    wr(dsc_pkg::OFS_BASE, 32'h100);
    wr(dsc_pkg::OFS_LEN, 32'h8);
    #1 chk("idle", 32'h0, {31'h0, idle});
    wr(dsc_pkg::OFS_BASE, 32'h900);
    wr(dsc_pkg::OFS_LEN, 32'h20);
    wait_idle();
    rd(dsc_pkg::OFS_LEN, 32'h8);
    rd(dsc_pkg::OFS_NEXT, 32'h108);
    wr(dsc_pkg::OFS_BASE, 32'h108);
    slow <= 1'b0;
    wr(dsc_pkg::OFS_LEN, 32'h38);
    wait_idle();
    rd(dsc_pkg::OFS_NEXT, 32'h140);
    rd(dsc_pkg::OFS_LVL, 32'(2 * (32 - wrc)));
  endtask
  task automatic t_normal();
    wr(dsc_pkg::OFS_NUM, 32'h3);
    seq_enable <= 1'b1;
    strobe(0);
    chk("active", 32'h1, {31'h0, act});
    rd(dsc_pkg::OFS_CNT, 32'h0);
    conv(28'h1, 1'b1);
    conv(28'h2, 1'b1);
    conv(28'h3, 1'b0);
    wr(dsc_pkg::OFS_NUM, 32'h0);
    strobe(0);
    rd(dsc_pkg::OFS_CNT, 32'h0);
    conv(28'h1, 1'b1);
    conv(28'h2, 1'b1);
    @(posedge ref_clk);
    seq_enable <= 1'b0;
  endtask
  task automatic t_frame();
    wr(dsc_pkg::OFS_NUM, 32'h2);
    frame_mode <= 1'b1;
    seq_enable <= 1'b1;
    strobe(1);
    chk("active", 32'h1, {31'h0, act});
    rd(dsc_pkg::OFS_CNT, 32'h0);
    conv(28'h1, 1'b1);
    conv(28'h2, 1'b0);
    strobe(1);
    rd(dsc_pkg::OFS_CNT, 32'h0);
    conv(28'h1, 1'b1);
    strobe(1);
    chk("frame_error", 32'h1, {31'h0, frm_err});
    rd(dsc_pkg::OFS_CNT, 32'h1);
    chk("data_error", 32'h0, {31'h0, dat_err});
  endtask
  task automatic t_devices();
    @(posedge ref_clk);
    seq_enable <= 1'b0;
    frame_mode <= 1'b0;
    devs <= 2'h1;
    wr(dsc_pkg::OFS_BASE, 32'h140);
    wr(dsc_pkg::OFS_LEN, 32'h20);
    wait_idle();
    wr(dsc_pkg::OFS_NUM, 32'h1);
    seq_enable <= 1'b1;
    repeat (10) @(posedge ref_clk);
    strobe(0);
    conv(28'h1, 1'b0);
    chk("dac_writes", 32'h30, 32'(wrc));
    strobe(0);
    strobe(2);
    strobe(0);
    strobe(2);
    chk("data_error", 32'h1, {31'h0, dat_err});
    rd(dsc_pkg::OFS_STAT, 32'ha);
  endtask
  task automatic end_sim();
    if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    t_reset();
    t_fetch();
    t_normal();
    t_frame();
    t_devices();
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    end_sim();
  end
endmodule
`default_nettype wire
